// *** hw/rxqs_pkg.sv ***
package rxqs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register indices as seen on the host register port
    localparam logic [7:0]  ADDR_MAX_LEN   = 8'hb6;
    localparam logic [7:0]  ADDR_MIN_LEN   = 8'hb7;
    localparam logic [7:0]  ADDR_LO_FRAMES = 8'hb8;
    localparam logic [7:0]  ADDR_HI_FRAMES = 8'hb9;
    localparam logic [7:0]  ADDR_LO_HWORDS = 8'hba;
    localparam logic [7:0]  ADDR_HI_HWORDS = 8'hbb;

    ////////////////////////////////////////////////////////////////////////////
    // field widths and reset values
    localparam int          LEN_W          = 16;
    localparam int          FRM_W          = 9;
    localparam int          HW_W           = 14;
    localparam logic [15:0] MIN_LEN_RESET  = 16'h0040;
    localparam logic [15:0] MAX_LEN_RESET  = 16'h0618;

    ////////////////////////////////////////////////////////////////////////////
    // per-queue event bundle from the receive mac and host read path
    typedef struct packed {
        logic       hw_push;
        logic       hw_pop;
        logic       frame_push;
        logic       frame_pop;
    } rxqs_qev_t;

    typedef struct packed {
        logic [8:0]  frames;
        logic [13:0] hwords;
    } rxqs_occ_t;

endpackage

// *** hw/rxqs_occ_counter.sv ***
`timescale 1ns/10ps
module rxqs_occ_counter (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // queue events
    input  wire rxqs_pkg::rxqs_qev_t ev,
    // occupancy
    output rxqs_pkg::rxqs_occ_t      occ
);

    rxqs_pkg::rxqs_occ_t occ_ff;
    rxqs_pkg::rxqs_occ_t nxt_occ;

    // simultaneous push and pop cancel; counts saturate instead of wrapping
    always_comb begin
        nxt_occ = occ_ff;
        if (ev.hw_push && !ev.hw_pop && occ_ff.hwords != '1) begin
            nxt_occ.hwords = occ_ff.hwords + 14'h0001;
        end else if (ev.hw_pop && !ev.hw_push && occ_ff.hwords != '0) begin
            nxt_occ.hwords = occ_ff.hwords - 14'h0001;
        end
        if (ev.frame_push && !ev.frame_pop && occ_ff.frames != '1) begin
            nxt_occ.frames = occ_ff.frames + 9'h001;
        end else if (ev.frame_pop && !ev.frame_push && occ_ff.frames != '0) begin
            nxt_occ.frames = occ_ff.frames - 9'h001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            occ_ff <= '0;
        end else begin
            occ_ff <= nxt_occ;
        end
    end

    assign occ = occ_ff;

endmodule

// *** hw/rxqs_regs.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module rxqs_regs (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                nrst,
    // host register port
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    output logic [31:0]              reg_rdata,
    output logic                     reg_rvalid,
    // queue events
    input  wire rxqs_pkg::rxqs_qev_t lo_ev,
    input  wire rxqs_pkg::rxqs_qev_t hi_ev,
    // to frame length checker and host status
    output logic [15:0]              min_rx_length_field,
    output logic [15:0]              max_rx_length_field,
    output logic                     receive_ready_flag
);

    ////////////////////////////////////////////////////////////////////////////
    // reset release; both stages drop at once, lift on successive edges
    // counters and settings all wait on the second stage
    logic       rst_s1_ff;
    logic       rst_n_ff;
    logic       nxt_rst_s1;
    logic       nxt_rst_n;

    always_comb begin
        nxt_rst_s1 = 1'b1;
        nxt_rst_n  = rst_s1_ff;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_ff <= 1'b0;
            rst_n_ff  <= 1'b0;
        end else begin
            rst_s1_ff <= nxt_rst_s1;
            rst_n_ff  <= nxt_rst_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // occupancy counters
    // events come from the mac on this clock, so no synchroniser
    rxqs_pkg::rxqs_occ_t lo_occ;
    rxqs_pkg::rxqs_occ_t hi_occ;

    rxqs_occ_counter u_lo (
        .clk   (clk),
        .rst_n (rst_n_ff),
        .ev    (lo_ev),
        .occ   (lo_occ)
    );

    rxqs_occ_counter u_hi (
        .clk   (clk),
        .rst_n (rst_n_ff),
        .ev    (hi_ev),
        .occ   (hi_occ)
    );

    ////////////////////////////////////////////////////////////////////////////
    // address decode
    function automatic logic addr_hit(
        input logic [7:0] a,
        input logic [7:0] target
    );
        return a == target;
    endfunction

    // only the two length settings take writes; counts ignore them
    logic        wr_min;
    logic        wr_max;

    assign wr_min = reg_wr && addr_hit(reg_addr, rxqs_pkg::ADDR_MIN_LEN);
    assign wr_max = reg_wr && addr_hit(reg_addr, rxqs_pkg::ADDR_MAX_LEN);

    ////////////////////////////////////////////////////////////////////////////
    // minimum length setting
    // no check against the maximum; software keeps min below max
    logic [rxqs_pkg::LEN_W-1:0] min_len_ff;
    logic [rxqs_pkg::LEN_W-1:0] nxt_min_len;

    always_comb begin
        nxt_min_len = min_len_ff;
        if (wr_min) begin
            nxt_min_len = reg_wdata[rxqs_pkg::LEN_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            min_len_ff <= rxqs_pkg::MIN_LEN_RESET;
        end else begin
            min_len_ff <= nxt_min_len;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // maximum length setting
    logic [rxqs_pkg::LEN_W-1:0] max_len_ff;
    logic [rxqs_pkg::LEN_W-1:0] nxt_max_len;

    always_comb begin
        nxt_max_len = max_len_ff;
        if (wr_max) begin
            nxt_max_len = reg_wdata[rxqs_pkg::LEN_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            max_len_ff <= rxqs_pkg::MAX_LEN_RESET;
        end else begin
            max_len_ff <= nxt_max_len;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path; writes to read-only counts are ignored
    // reserved upper bits always read as zero
    function automatic logic [31:0] pad_len(input logic [rxqs_pkg::LEN_W-1:0] v);
        return {16'h0, v};
    endfunction

    function automatic logic [31:0] pad_frm(input logic [rxqs_pkg::FRM_W-1:0] v);
        return {23'h0, v};
    endfunction

    function automatic logic [31:0] pad_hw(input logic [rxqs_pkg::HW_W-1:0] v);
        return {18'h0, v};
    endfunction

    // unmapped indices read as zero, still with a valid pulse
    function automatic logic [31:0] rd_mux(
        input logic [7:0]          a,
        input logic [15:0]         mn,
        input logic [15:0]         mx,
        input rxqs_pkg::rxqs_occ_t lo,
        input rxqs_pkg::rxqs_occ_t hi
    );
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (a)
            rxqs_pkg::ADDR_MIN_LEN:   r = pad_len(mn);
            rxqs_pkg::ADDR_MAX_LEN:   r = pad_len(mx);
            rxqs_pkg::ADDR_LO_FRAMES: r = pad_frm(lo.frames);
            rxqs_pkg::ADDR_HI_FRAMES: r = pad_frm(hi.frames);
            rxqs_pkg::ADDR_LO_HWORDS: r = pad_hw(lo.hwords);
            rxqs_pkg::ADDR_HI_HWORDS: r = pad_hw(hi.hwords);
            default:                  r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    logic [31:0] rdata_ff;
    logic        rvalid_ff;
    logic [31:0] nxt_rdata;
    logic        nxt_rvalid;

    // data holds until the next read, so a slow host can still pick it up
    always_comb begin
        nxt_rdata  = rdata_ff;
        nxt_rvalid = reg_rd;
        if (reg_rd) begin
            nxt_rdata = rd_mux(reg_addr, min_len_ff, max_len_ff, lo_occ, hi_occ);
        end
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rdata_ff  <= 32'h0000_0000;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive ready status
    function automatic logic has_frame(input rxqs_pkg::rxqs_occ_t q);
        return q.frames != '0;
    endfunction

    logic        rdy_ff;
    logic        nxt_rdy;

    // counts are debug views; this flag is what software polls
    // host only needs one whole frame in either queue
    always_comb begin
        nxt_rdy = has_frame(lo_occ) || has_frame(hi_occ);
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rdy_ff <= 1'b0;
        end else begin
            rdy_ff <= nxt_rdy;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flops
    assign reg_rdata           = rdata_ff;
    assign reg_rvalid          = rvalid_ff;
    assign receive_ready_flag  = rdy_ff;
    assign min_rx_length_field = min_len_ff;
    assign max_rx_length_field = max_len_ff;

endmodule

// *** verif/rxqs_host.sv ***
`timescale 1ns/10ps
module rxqs_host (
    // host register port
    input  wire logic        clk,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [7:0]       reg_addr,
    output logic [31:0]      reg_wdata,
    input  wire logic [31:0] reg_rdata,
    input  wire logic        reg_rvalid
);
    // released lines show inverted values so stale data never decodes
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
        @(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~v};
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v, output logic ok);
        @(negedge clk) {reg_rd, reg_addr} = {1'b1, a};
        // answer stands for the cycle after the strobe edge
        @(negedge clk) begin
            v  = reg_rdata;
            ok = reg_rvalid;
            {reg_rd, reg_addr} = {1'b0, ~a};
        end
    endtask
endmodule

// *** verif/rxqs_regs_props.sv ***
`timescale 1ns/10ps
module rxqs_regs_props (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 nrst,
    // register port
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [7:0]           reg_addr,
    input wire logic [31:0]          reg_wdata,
    input wire logic [31:0]          reg_rdata,
    input wire logic                 reg_rvalid,
    // queue side and outputs
    input wire rxqs_pkg::rxqs_qev_t  lo_ev,
    input wire logic [15:0]          min_rx_length_field,
    input wire logic [15:0]          max_rx_length_field,
    input wire logic                 receive_ready_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence rd_at(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    sequence wr_at(logic [7:0] a);
        reg_wr && reg_addr == a;
    endsequence
    chk_min_read:
    assert property (rd_at(8'hb7) |=> reg_rdata == {16'h0, $past(min_rx_length_field)}) else $error("min read");
    chk_min_write:
    assert property (wr_at(8'hb7) |=> min_rx_length_field == $past(reg_wdata[15:0])) else $error("min write");
    chk_max_write:
    assert property (wr_at(8'hb6) |=> max_rx_length_field == $past(reg_wdata[15:0])) else $error("max write");
    chk_lo_frm_top:
    assert property (rd_at(8'hb8) |=> reg_rvalid && reg_rdata[31:9] == 23'h0) else $error("lo frames");
    chk_hi_frm_top:
    assert property (rd_at(8'hb9) |=> reg_rvalid && reg_rdata[31:9] == 23'h0) else $error("hi frames");
    chk_lo_hw_top:
    assert property (rd_at(8'hba) |=> reg_rdata[31:14] == 18'h0) else $error("lo hwords");
    chk_hi_hw_top:
    assert property (rd_at(8'hbb) |=> reg_rdata[31:14] == 18'h0) else $error("hi hwords");
    chk_ready_rise:
    assert property (lo_ev.frame_push && !lo_ev.frame_pop |-> ##2 receive_ready_flag) else $error("ready");
endmodule
bind rxqs_regs rxqs_regs_props rxqs_regs_props_inst (.*);

// *** verif/rxqs_regs_tb_top.sv ***
`timescale 1ns/10ps
module rxqs_regs_tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic reg_wr, reg_rd, reg_rvalid, receive_ready_flag;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [15:0] min_rx_length_field, max_rx_length_field;
    rxqs_pkg::rxqs_qev_t lo_ev = '0, hi_ev = '0;
    int errors = 0, n_checks = 0, cyc = 0;
    rxqs_regs rxqs_regs_inst (.clk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
        .lo_ev, .hi_ev, .min_rx_length_field, .max_rx_length_field, .receive_ready_flag);
    rxqs_host rxqs_host_inst (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid);
    initial forever #20 clk = ~clk;
    // run needs about 16,500 cycles, mostly the saturation fill
    always @(posedge clk) if (++cyc == 20000) begin
        errors++;
        complete_run;
    end
    ////////////////////////////////////////
    task chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task complete_run;
        if (errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task ev(input logic [3:0] l, h, input int n);
        repeat (n) begin
            @(negedge clk);
            lo_ev = l;
            hi_ev = h;
        end
        @(negedge clk);
        lo_ev = '0;
        hi_ev = '0;
    endtask
    task rd_seq(input logic [7:0] base, input logic [0:6][31:0] e, input int n);
        logic ok;
        for (int i = 0; i < n; i++) begin
            rxqs_host_inst.rd(base + 8'(i), d, ok);
            chk("rvalid", 32'h1, {31'h0, ok});
            chk("reg", e[i], d);
        end
    endtask
    ////////////////////////////////////////
    // unmapped 0xb5 first, then the whole bank
    task t_reset;
        rd_seq(8'hb5, {32'h0, 32'h618, 32'h40, 32'h0, 32'h0, 32'h0, 32'h0}, 7);
    endtask
    task t_len;
        rxqs_host_inst.wr(8'hb7, 32'hffff_0005);
        rxqs_host_inst.wr(8'hb6, 32'h1234_5678);
        rxqs_host_inst.wr(8'hb8, 32'hffff_ffff);
        chk("min", 32'h5, {16'h0, min_rx_length_field});
        chk("max", 32'h5678, {16'h0, max_rx_length_field});
        rd_seq(8'hb6, {32'h5678, 32'h5, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0}, 3);
    endtask
    // push+pop pairs must cancel; extra pops must floor at zero
    task t_queue;
        ev(4'h2, 4'h0, 3);
        ev(4'h8, 4'h2, 5);
        ev(4'h0, 4'h8, 2);
        ev(4'hc, 4'h3, 2);
        chk("rdy", 32'h1, {31'h0, receive_ready_flag});
        rd_seq(8'hb8, {32'h3, 32'h5, 32'h5, 32'h2, 32'h0, 32'h0, 32'h0}, 4);
        ev(4'h5, 4'h5, 6);
        rd_seq(8'hb8, {32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0}, 4);
        chk("rdy", 32'h0, {31'h0, receive_ready_flag});
    endtask
    // counts must hold at all-ones rather than wrap
    task t_sat;
        ev(4'ha, 4'h0, 16400);
        rd_seq(8'hb8, {32'h1ff, 32'h0, 32'h3fff, 32'h0, 32'h0, 32'h0, 32'h0}, 4);
        chk("rdy", 32'h1, {31'h0, receive_ready_flag});
    endtask
    initial begin
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
        t_len;
        t_queue;
        t_sat;
        complete_run;
    end
endmodule
